// ---- rtl/ttf_pkg.sv ----
// Package for the turn-on timeout fault response block
package ttf_pkg;

  // ==========================================================================
  // Command port
  // ==========================================================================
  localparam logic [7:0] CMD_REACTION      = 8'h63;
  localparam logic [7:0] REACTION_RESET    = 8'hC0;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] code;
    logic [7:0] data;
  } ttf_cmd_t;

  // ==========================================================================
  // Reaction register fields
  // ==========================================================================
  localparam int RESP_MSB  = 7;
  localparam int RESP_LSB  = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int DELAY_MSB = 2;
  localparam int DELAY_LSB = 0;

  localparam logic [1:0] RESP_IGNORE   = 2'h0;
  localparam logic [1:0] RESP_DELAYED  = 2'h1;
  localparam logic [1:0] RESP_RETRY    = 2'h2;
  localparam logic [1:0] RESP_LATCH    = 2'h3;
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_MAX     = 3'h4;

  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] dly;
  } ttf_cfg_t;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_FREQ_HZ  = 10000000;
  localparam int TICK_TIME_US = 1000;
  localparam int UNIT_TIME_US = 1000;
  localparam int MS_CYCLES    = CLK_FREQ_HZ / 1000000 * TICK_TIME_US;
  localparam int UNIT_CYCLES  = CLK_FREQ_HZ / 1000000 * UNIT_TIME_US;

  // ==========================================================================
  // Sequencer states, Gray coded along off, ramp, run, delay, wait, latched
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_OFF     = 3'h0,
    ST_RAMP    = 3'h1,
    ST_RUN     = 3'h3,
    ST_DELAY   = 3'h2,
    ST_WAIT    = 3'h6,
    ST_LATCHED = 3'h7
  } ttf_state_t;

endpackage : ttf_pkg

// ---- rtl/ttf_core.sv ----
// Turn-on timeout fault detection and configurable fault response sequencer
// Functional notes
// - Response 00: keep output on when the turn-on timeout fault occurs.
// - Response 01: keep running for delay units, then act per retry field if fault remains.
// - Response 10: disable output at once, then follow the retry field.
// - Response 11: disable output and hold it off until a clearing event.
// - Latch releases on individual status clear or on the clear-faults command.
// - Latch releases on reset or on commanding output off then on.
// - Retry field 000: no restart, output stays off until cleared.
// - Retry codes 001..100 give one to four restarts, then latch off.
// - Under response 10, restart attempts start one delay period apart, measured from attempt start.
// - Delay code n means two to the power n delay units.
// - Fault when output misses undervoltage limit within limit; limit zero disables.
`timescale 1ns/100ps
module ttf_core #(
  parameter int MS_CYCLES   = ttf_pkg::MS_CYCLES,
  parameter int UNIT_CYCLES = ttf_pkg::UNIT_CYCLES
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire ttf_pkg::ttf_cmd_t cmd_in,
  input  wire logic             clear_faults_in,
  input  wire logic             status_clear_in,
  input  wire logic             operation_on_in,
  input  wire logic             ctrl_on_in,
  input  wire logic             vout_above_uv_in,
  input  wire logic [15:0]      ton_limit_ms_in,
  output logic                  output_enable_out,
  output logic                  fault_status_out,
  output logic                  latched_out,
  output logic [7:0]            rd_data_out,
  output logic                  rd_ack_out
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [7:0] dly_units(input logic [2:0] code);
    dly_units = 8'h01 << code;
  endfunction : dly_units

  function automatic logic [7:0] clamp_cfg(input logic [7:0] wdata);
    logic [2:0] retry;
    retry = wdata[ttf_pkg::RETRY_MSB:ttf_pkg::RETRY_LSB];
    if (retry > ttf_pkg::RETRY_MAX) begin
      retry = ttf_pkg::RETRY_MAX;
    end
    clamp_cfg = {wdata[ttf_pkg::RESP_MSB:ttf_pkg::RESP_LSB], retry,
                 wdata[ttf_pkg::DELAY_MSB:ttf_pkg::DELAY_LSB]};
  endfunction : clamp_cfg

  // ==========================================================================
  // Registers
  // ==========================================================================
  ttf_pkg::ttf_cfg_t   cfg_reg;
  ttf_pkg::ttf_state_t state_reg;
  ttf_pkg::ttf_state_t state_next;
  logic [15:0]         tick_cnt_reg;
  logic [15:0]         unit_tick_reg;
  logic [15:0]         ms_cnt_reg;
  logic [7:0]          unit_cnt_reg;
  logic [2:0]          retries_left_reg;
  logic [2:0]          retries_left_next;

  // ==========================================================================
  // Decode
  // ==========================================================================
  wire        hit_cfg      = cmd_in.code == ttf_pkg::CMD_REACTION;
  wire        cfg_wr       = cmd_in.wr & hit_cfg;
  wire        on_req       = operation_on_in & ctrl_on_in;
  wire        clear_evt    = clear_faults_in | status_clear_in;
  wire        ms_tick      = tick_cnt_reg == 16'(MS_CYCLES - 1);
  wire        unit_tick    = unit_tick_reg == 16'(UNIT_CYCLES - 1);
  wire        limit_on     = ton_limit_ms_in != 16'h0000;
  wire        timeout      = limit_on & (ms_cnt_reg >= ton_limit_ms_in) & ~vout_above_uv_in;
  // Look one unit tick ahead so that the spacing is exactly the programmed period
  wire        delay_done   = (unit_cnt_reg >= dly_units(cfg_reg.dly)) ||
                             (unit_tick && (unit_cnt_reg + 8'h01) >= dly_units(cfg_reg.dly));
  wire        restart_cnt  = (state_next == ttf_pkg::ST_RAMP && state_reg != ttf_pkg::ST_RAMP) ||
                             (state_next == ttf_pkg::ST_DELAY && state_reg != ttf_pkg::ST_DELAY);
  wire        fault_set    = state_reg == ttf_pkg::ST_RAMP && timeout;

  // Where a retry may be spent: latch when none left, otherwise wait and restart
  wire ttf_pkg::ttf_state_t retry_target = (retries_left_reg == ttf_pkg::RETRY_NONE) ?
                                           ttf_pkg::ST_LATCHED : ttf_pkg::ST_WAIT;

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_comb begin
    state_next        = state_reg;
    retries_left_next = retries_left_reg;
    case (state_reg)
      ttf_pkg::ST_OFF: begin
        if (on_req) begin
          state_next        = ttf_pkg::ST_RAMP;
          retries_left_next = cfg_reg.retry;
        end
      end
      ttf_pkg::ST_RAMP: begin
        if (vout_above_uv_in) begin
          state_next = ttf_pkg::ST_RUN;
        end else if (timeout) begin
          case (cfg_reg.resp)
            ttf_pkg::RESP_IGNORE:  state_next = ttf_pkg::ST_RUN;
            ttf_pkg::RESP_DELAYED: state_next = ttf_pkg::ST_DELAY;
            ttf_pkg::RESP_RETRY:   state_next = retry_target;
            default:               state_next = ttf_pkg::ST_LATCHED;
          endcase
        end
      end
      ttf_pkg::ST_RUN: begin
        state_next = ttf_pkg::ST_RUN;
      end
      ttf_pkg::ST_DELAY: begin
        if (delay_done) begin
          // A fault that has cleared by now needs no further action
          state_next = vout_above_uv_in ? ttf_pkg::ST_RUN : retry_target;
        end
      end
      ttf_pkg::ST_WAIT: begin
        // Counter keeps running from the start of the failed attempt, or from the start of ST_DELAY under response 01
        if (delay_done) begin
          state_next        = ttf_pkg::ST_RAMP;
          retries_left_next = retries_left_reg - 3'h1;
        end
      end
      ttf_pkg::ST_LATCHED: begin
        if (clear_evt) begin
          state_next = ttf_pkg::ST_OFF;
        end
      end
      default: begin
        state_next = ttf_pkg::ST_OFF;
      end
    endcase
    // Commanding off always wins and arms the off-then-on release
    if (!on_req) begin
      state_next = ttf_pkg::ST_OFF;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_reg        <= ttf_pkg::ST_OFF;
      retries_left_reg <= ttf_pkg::RETRY_NONE;
    end else if (ce_in) begin
      state_reg        <= state_next;
      retries_left_reg <= retries_left_next;
    end
  end

  // ==========================================================================
  // Timers: millisecond base for the limit, delay units for the response
  // ==========================================================================
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tick_cnt_reg  <= 16'h0000;
      unit_tick_reg <= 16'h0000;
      ms_cnt_reg    <= 16'h0000;
      unit_cnt_reg  <= 8'h00;
    end else if (ce_in) begin
      if (restart_cnt) begin
        tick_cnt_reg  <= 16'h0000;
        unit_tick_reg <= 16'h0000;
        ms_cnt_reg    <= 16'h0000;
        unit_cnt_reg  <= 8'h00;
      end else begin
        tick_cnt_reg  <= ms_tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
        unit_tick_reg <= unit_tick ? 16'h0000 : unit_tick_reg + 16'h0001;
        if (ms_tick && ms_cnt_reg != 16'hFFFF) begin
          ms_cnt_reg <= ms_cnt_reg + 16'h0001;
        end
        if (unit_tick && unit_cnt_reg != 8'hFF) begin
          unit_cnt_reg <= unit_cnt_reg + 8'h01;
        end
      end
    end
  end

  // ==========================================================================
  // Configuration and status
  // ==========================================================================
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cfg_reg          <= ttf_pkg::REACTION_RESET;
      fault_status_out <= 1'b0;
      rd_data_out      <= 8'h00;
      rd_ack_out       <= 1'b0;
    end else if (ce_in) begin
      if (cfg_wr) begin
        cfg_reg <= clamp_cfg(cmd_in.data);
      end
      // A new fault in the clearing cycle is kept
      if (fault_set) begin
        fault_status_out <= 1'b1;
      end else if (clear_evt) begin
        fault_status_out <= 1'b0;
      end
      rd_ack_out  <= cmd_in.rd & hit_cfg;
      rd_data_out <= (cmd_in.rd & hit_cfg) ? cfg_reg : 8'h00;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      output_enable_out <= 1'b0;
      latched_out       <= 1'b0;
    end else if (ce_in) begin
      output_enable_out <= state_next == ttf_pkg::ST_RAMP || state_next == ttf_pkg::ST_RUN ||
                           state_next == ttf_pkg::ST_DELAY;
      latched_out       <= state_next == ttf_pkg::ST_LATCHED;
    end
  end

endmodule : ttf_core

// ---- testbench/ttf_core_monitor.sv ----
// Checker for the turn-on timeout fault response block
`timescale 1ns/100ps
module ttf_core_monitor #(
  parameter int MS_CYCLES   = 4,
  parameter int UNIT_CYCLES = 4
) (
  input wire logic              clk_sys_in,
  input wire logic              rst_n_in,
  input wire logic              ce_in,
  input wire ttf_pkg::ttf_cmd_t cmd_in,
  input wire logic              clear_faults_in,
  input wire logic              status_clear_in,
  input wire logic              operation_on_in,
  input wire logic              ctrl_on_in,
  input wire logic              vout_above_uv_in,
  input wire logic [15:0]       ton_limit_ms_in,
  input wire logic              output_enable_out,
  input wire logic              fault_status_out,
  input wire logic              latched_out,
  input wire logic [7:0]        rd_data_out,
  input wire logic              rd_ack_out
);
  // ==========
  // Properties
  wire rd_hit = ce_in && cmd_in.rd && cmd_in.code == ttf_pkg::CMD_REACTION;
  wire on_req = operation_on_in && ctrl_on_in;
  wire clr    = clear_faults_in || status_clear_in;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_clear_hit;
    latched_out && clr && ce_in;
  endsequence
  property p_read; rd_hit |=> rd_ack_out; endproperty
  property p_noack; !rd_hit && ce_in |=> !rd_ack_out; endproperty
  property p_data; !rd_ack_out |-> rd_data_out == 8'h00; endproperty
  property p_latch_off; latched_out |-> !output_enable_out; endproperty
  property p_hold; latched_out && !clr && on_req && ce_in |=> latched_out; endproperty
  property p_release; s_clear_hit |=> !latched_out; endproperty
  property p_off; ce_in && !on_req |=> !output_enable_out && !latched_out; endproperty
  property p_turn_on; ce_in && $rose(on_req) |=> output_enable_out; endproperty
  property p_sticky; fault_status_out && !clr && ce_in |=> fault_status_out; endproperty
  property p_limit0; $rose(fault_status_out) |-> $past(ton_limit_ms_in) != 16'h0000; endproperty
  a_read: assert property (p_read) else $error("read not acknowledged");
  a_noack: assert property (p_noack) else $error("spurious acknowledge");
  a_data: assert property (p_data) else $error("read data without acknowledge");
  a_latch_off: assert property (p_latch_off) else $error("output on while latched");
  a_hold: assert property (p_hold) else $error("latch dropped without clear");
  a_release: assert property (p_release) else $error("clear did not release latch");
  a_off: assert property (p_off) else $error("off command ignored");
  a_turn_on: assert property (p_turn_on) else $error("on command ignored");
  a_sticky: assert property (p_sticky) else $error("fault flag lost");
  a_limit0: assert property (p_limit0) else $error("fault with zero limit");
endmodule : ttf_core_monitor

bind ttf_core ttf_core_monitor #(.MS_CYCLES(MS_CYCLES), .UNIT_CYCLES(UNIT_CYCLES)) ttf_core_monitor_i (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .cmd_in(cmd_in),
  .clear_faults_in(clear_faults_in), .status_clear_in(status_clear_in),
  .operation_on_in(operation_on_in), .ctrl_on_in(ctrl_on_in), .vout_above_uv_in(vout_above_uv_in),
  .ton_limit_ms_in(ton_limit_ms_in), .output_enable_out(output_enable_out),
  .fault_status_out(fault_status_out), .latched_out(latched_out), .rd_data_out(rd_data_out),
  .rd_ack_out(rd_ack_out));

// ---- testbench/ttf_conv_model.sv ----
// Behavioural model of the converter output stage
`timescale 1ns/100ps
module ttf_conv_model (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       enable_in,
  input  wire logic [7:0] rise_in,
  output logic            vout_ok_out
);
  logic [7:0] cnt_reg;
  // Zero rise time models an output that never reaches the limit
  assign vout_ok_out = rise_in != 8'h00 && cnt_reg >= rise_in;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || !enable_in) begin
      cnt_reg <= 8'h00;
    end else if (cnt_reg != 8'hFF) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
endmodule : ttf_conv_model

// ---- testbench/testbench.sv ----
// Self-checking testbench for the fault response block
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rise;
    logic [7:0] n_on;
    logic [2:0] lat_oe_flt;
    logic [7:0] gap;
  } ttf_row_t;
  logic clk = 0, rst_n = 0, clf = 0, stc = 0, op_on = 0, ct_on = 0, ce = 1;
  ttf_pkg::ttf_cmd_t cmd = '0;
  logic [15:0] lim = 16'h0001;
  logic [7:0]  rise = 8'h00, rdd;
  logic        vout, oe, flt, lat, ack;
  int          fails = 0, samples_checked = 0;
  ttf_row_t    rows[8] = '{
    '{8'h80, 8'h00, 8'h01, 3'b101, 8'h00},
    '{8'h89, 8'h00, 8'h02, 3'b101, 8'h08},
    '{8'hA3, 8'h00, 8'h05, 3'b101, 8'h20},
    '{8'hD0, 8'h00, 8'h01, 3'b101, 8'h00},
    '{8'h00, 8'h00, 8'h01, 3'b011, 8'h00},
    '{8'h48, 8'h00, 8'h02, 3'b101, 8'h00},
    '{8'h44, 8'h08, 8'h01, 3'b011, 8'h00},
    '{8'h80, 8'h02, 8'h01, 3'b010, 8'h00}};
  ttf_core #(.MS_CYCLES(4), .UNIT_CYCLES(4)) ttf_core_i (.clk_sys_in(clk), .rst_n_in(rst_n), .ce_in(ce),
    .cmd_in(cmd), .clear_faults_in(clf), .status_clear_in(stc), .operation_on_in(op_on), .ctrl_on_in(ct_on),
    .vout_above_uv_in(vout), .ton_limit_ms_in(lim), .output_enable_out(oe), .fault_status_out(flt),
    .latched_out(lat), .rd_data_out(rdd), .rd_ack_out(ack));
  ttf_conv_model ttf_conv_model_i (.clk_in(clk), .rst_n_in(rst_n), .enable_in(oe), .rise_in(rise),
    .vout_ok_out(vout));
  initial begin
    forever #50 clk = ~clk;
  end
  // ==========
  // Tasks
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(negedge clk);
  endtask : tk
  task automatic wr(input logic [7:0] d);
    cmd = '{1'b1, 1'b0, 8'h63, d};
    tk(1);
    cmd = '0;
    tk(1);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [7:0] e, input logic ea);
    cmd = '{1'b0, 1'b1, c, 8'h00};
    tk(1);
    // Acknowledge and data stand for the one cycle after the read edge
    chk({7'h00, ack}, {7'h00, ea}, "ack");
    chk(rdd, e, "read data");
    cmd = '0;
    tk(1);
  endtask : rd
  task automatic pulse_clear;
    op_on = 0;
    clf = 1;
    tk(1);
    clf = 0;
    tk(3);
  endtask : pulse_clear
  task automatic do_reset;
    rst_n = 0;
    tk(10);
    rst_n = 1;
    chk({5'h00, lat, oe, flt}, 8'h00, "reset outputs");
    rd(8'h63, 8'hC0, 1'b1);
  endtask : do_reset
  task automatic run_row(input ttf_row_t r);
    int n, last, gap;
    logic pv;
    n = 0;
    last = 0;
    gap = 0;
    pv = 0;
    wr(r.cfg);
    rd(8'h63, r.cfg, 1'b1);
    rise = r.rise;
    op_on = 1;
    for (int c = 0; c < 300; c++) begin
      tk(1);
      if (oe && !pv) begin
        gap = c - last;
        last = c;
        n++;
      end
      pv = oe;
    end
    chk(8'(n), r.n_on, "attempts");
    chk({5'h00, lat, oe, flt}, {5'h00, r.lat_oe_flt}, "lat oe fault");
    if (r.gap != 0) chk(8'(gap), r.gap, "spacing");
    pulse_clear;
  endtask : run_row
  task automatic summarize;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // ==========
  // Main sequence
  initial begin
    ct_on = 1;
    tk(1);
    do_reset;
    foreach (rows[i]) run_row(rows[i]);
    rise = 8'h00;
    wr(8'hD0);
    op_on = 1;
    tk(20);
    chk({7'h00, lat}, 8'h01, "latched");
    stc = 1;
    tk(1);
    stc = 0;
    chk({6'h00, lat, flt}, 8'h00, "status clear");
    tk(20);
    chk({7'h00, lat}, 8'h01, "relatched");
    ce = 0;
    clf = 1;
    tk(1);
    clf = 0;
    tk(2);
    ce = 1;
    chk({7'h00, lat}, 8'h01, "clear while frozen");
    ct_on = 0;
    tk(2);
    ct_on = 1;
    tk(2);
    chk({6'h00, lat, oe}, 8'h01, "off then on");
    wr(8'hFF);
    rd(8'h63, 8'hE7, 1'b1);
    rd(8'h62, 8'h00, 1'b0);
    pulse_clear;
    lim = 16'h0000;
    wr(8'h80);
    op_on = 1;
    tk(100);
    chk({6'h00, oe, flt}, 8'h02, "no limit");
    lim = 16'h0001;
    tk(20);
    chk({6'h00, lat, flt}, 8'h03, "limit restored");
    do_reset;
    summarize;
  end
endmodule : testbench
